//--- usb_host_ctrl_defs.vh
// Register map, field positions, reset values and timing counts for the
// USB host control register block. Definitions only; included by bare name.
`ifndef USB_HOST_CTRL_DEFS_VH
`define USB_HOST_CTRL_DEFS_VH

// -----------------------------------------------------------------------------
// Register byte addresses (APB, one aligned word each)
// -----------------------------------------------------------------------------
`define ADDR_HOST_CONTROL_LOWER   12'h000
`define ADDR_HOST_CONTROL_UPPER   12'h004
`define ADDR_HOST_EVENT_FLAGS     12'h008
`define ADDR_SIDE_CONTROL         12'h00c

// -----------------------------------------------------------------------------
// host_control_lower fields
// -----------------------------------------------------------------------------
`define LOW_ROLE_BIT              0
`define LOW_BUS_RESET_BIT         1
`define LOW_ENABLES_LSB           2
`define LOW_RESET_VALUE           8'h00

// -----------------------------------------------------------------------------
// host_control_upper fields (register bits 10:8 sit at 2:0 here)
// -----------------------------------------------------------------------------
`define UP_RETRY_BIT              0
`define UP_CANCEL_BIT             1
`define UP_EVERY_FRAME_BIT        2
`define UP_RESET_VALUE            8'h01

// -----------------------------------------------------------------------------
// host_event_flags fields
// -----------------------------------------------------------------------------
`define EV_FRAME_START            0
`define EV_DETACH                 1
`define EV_ATTACH                 2
`define EV_COMPLETION             3
`define EV_BUS_RESET_END          4
`define EV_RESUME                 5
`define EV_ABORTED                7

// -----------------------------------------------------------------------------
// side control register fields
// -----------------------------------------------------------------------------
`define SIDE_SOFT_RESET_BIT       0
`define SIDE_FRAME_COMPARE_LSB    8

// -----------------------------------------------------------------------------
// Token codes and timing
// -----------------------------------------------------------------------------
`define TOKEN_CODE_SOF            3'h1
`define CLK_PERIOD_NS             10
`define BUS_RESET_TIME_NS         10000
`define BUS_RESET_CYCLES          (`BUS_RESET_TIME_NS / `CLK_PERIOD_NS)
`define ROLE_SETTLE_CYCLES        4

`endif

//--- usb_host_control_regs.v
// Host-side control registers of a dual-role USB controller, on APB.
// Assumes a protocol engine on pclk that reports frame, token and error
// events as one-cycle pulses, and a USB line that is sampled asynchronously.
//
// Summary of operation
// [R1] Every-frame select high: each sent frame start not launched by token sets the frame-start flag.
// [R2] Every-frame select low: flag set only when compare equals low frame byte.
// [R3] Frame start launched by software token code 001 never sets that flag.
// [R4] Soft reset clears only bus reset command; other control bits stay.
// [R5] Cancel enabled: a token written inside end-of-frame window is not sent.
// [R6] Cancel disabled: every written token is sent, even inside the window.
// [R7] Each cancelled token sets the token-aborted flag.
// [R8] Retry enabled: resend token after NAK or receive/timeout/CRC/toggle/bitstuff_error_flag error.
// [R9] Retries are confined to the programmed retry period.
// [R10] Each of six events interrupts only when flag set and enable high.
// [R11] Writing 1 starts bus reset; bit reads 1 while driven, 0 after.
// [R12] Writing 0 to bus reset command does nothing to the bus.
// [R13] A bus reset request is ignored while soft reset is 1.
// [R14] Software must not start bus reset while suspended or sending a token.
// [R15] Software must not write control registers while bus reset reads 1.
// [R16] Role bit 1 selects host role, 0 selects device role.
// [R17] Software changes role only while soft reset is 1.
// [R18] Role change lags the write; role bit reflects the actual role.
// [R19] Before host-to-device, software checks idle state and asserts soft reset.
// [R20] Before device-to-host, software sets host-connect and drops upstream.
// [R21] Software writes 0 to the five reserved upper bits.
// [R22] A finished bus reset sets the bus-reset-end flag.
// [R23] Flags clear by writing 0; a written 1 is ignored.
// [R24] Control bits read back last written value; bus reset follows progress, role bit shows actual role.
`timescale 1ns/10ps
`include "usb_host_ctrl_defs.vh"

module usb_host_control_regs #(
	parameter BUS_RESET_CYCLES = `BUS_RESET_CYCLES,
	parameter RETRY_WIDTH      = 24
) (
	input  wire                   pclk,
	input  wire                   presetn,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [11:0]            paddr,
	input  wire [31:0]            pwdata,
	output reg  [31:0]            prdata,
	output reg                    pready,
	output reg                    pslverr,
	input  wire                   sof_sent,
	input  wire                   sof_by_token,
	input  wire [7:0]             frame_number_low,
	input  wire                   token_write,
	input  wire                   eof_window,
	input  wire                   token_done,
	input  wire                   token_nak,
	input  wire                   token_error,
	input  wire [RETRY_WIDTH-1:0] retry_period,
	input  wire                   resume_event,
	input  wire                   attach_event,
	input  wire                   detach_event,
	output reg                    token_launch,
	output reg                    token_retry,
	output reg                    bus_reset_drive,
	output reg                    host_role,
	output reg                    soft_reset,
	output reg                    host_irq
);

	// -------------------------------------------------------------------------
	// Register state
	// -------------------------------------------------------------------------
	reg [5:0]             int_enable;
	reg                   role_request;
	reg                   bus_reset_command;
	reg                   retry_enable;
	reg                   cancel_enable;
	reg                   every_frame_select;
	reg [4:0]             upper_reserved;
	reg [7:0]             frame_compare_value;
	reg [7:0]             host_event_flags;
	reg [31:0]            reset_count;
	reg [2:0]             role_count;
	reg                   token_active;
	reg [RETRY_WIDTH-1:0] retry_count;
	reg [31:0]            next_prdata;

	wire access       = psel & penable;
	wire write_access = access & pwrite;
	wire wr_low       = write_access & (paddr == `ADDR_HOST_CONTROL_LOWER);
	wire wr_up        = write_access & (paddr == `ADDR_HOST_CONTROL_UPPER);
	wire wr_flags     = write_access & (paddr == `ADDR_HOST_EVENT_FLAGS);
	wire wr_side      = write_access & (paddr == `ADDR_SIDE_CONTROL);
	wire reset_done   = bus_reset_command & (reset_count == BUS_RESET_CYCLES - 1);

	// Address decode used by the error answer; the read mux has its own case
	function mapped;
		input [11:0] a;
		begin
			mapped = (a == `ADDR_HOST_CONTROL_LOWER) | (a == `ADDR_HOST_CONTROL_UPPER) |
				(a == `ADDR_HOST_EVENT_FLAGS) | (a == `ADDR_SIDE_CONTROL);
		end
	endfunction

	// -------------------------------------------------------------------------
	// Line event synchronisers
	// -------------------------------------------------------------------------
	reg [2:0] line_meta;
	reg [2:0] line_sync;
	reg [2:0] line_prev;
	wire [2:0] line_rise = line_sync & ~line_prev;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_meta <= 3'h0;
			line_sync <= 3'h0;
			line_prev <= 3'h0;
		end else begin
			line_meta <= {resume_event, attach_event, detach_event};
			line_sync <= line_meta;
			line_prev <= line_sync;
		end
	end

	// -------------------------------------------------------------------------
	// Event sources feeding the flag register
	// -------------------------------------------------------------------------
	wire frame_hit   = every_frame_select |                      // [R1]
		(frame_compare_value == frame_number_low);                // [R2]
	wire frame_set   = sof_sent & ~sof_by_token & frame_hit;    // [R3]
	wire cancel_hit  = token_write & cancel_enable & eof_window; // [R5] [R6]

	wire [7:0] event_set;
	assign event_set[`EV_FRAME_START]   = frame_set;
	assign event_set[`EV_DETACH]        = line_rise[0];
	assign event_set[`EV_ATTACH]        = line_rise[1];
	assign event_set[`EV_COMPLETION]    = token_done;
	assign event_set[`EV_BUS_RESET_END] = reset_done;          // [R22]
	assign event_set[`EV_RESUME]        = line_rise[2];
	assign event_set[6]                 = 1'b0;
	assign event_set[`EV_ABORTED]       = cancel_hit;          // [R7]

	// Soft reset clears every flag except attach and detach
	wire [7:0] soft_clear_mask = 8'hf9;

	// -------------------------------------------------------------------------
	// Flags: set wins over a written clear
	// -------------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : flag_bits
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					host_event_flags[g] <= 1'b0;
				end else if (event_set[g]) begin
					host_event_flags[g] <= 1'b1;
				end else if (soft_reset && soft_clear_mask[g]) begin
					host_event_flags[g] <= 1'b0;
				end else if (wr_flags && !pwdata[g]) begin
					host_event_flags[g] <= 1'b0; // [R23]
				end
			end
		end
	endgenerate

	// -------------------------------------------------------------------------
	// Control registers
	// -------------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_enable          <= 6'h00;
			role_request        <= 1'b0;
			bus_reset_command   <= 1'b0;
			reset_count         <= 32'h0;
			retry_enable        <= 1'b1;
			cancel_enable       <= 1'b0;
			every_frame_select  <= 1'b0;
			upper_reserved      <= 5'h00;
			soft_reset          <= 1'b0;
			frame_compare_value <= 8'h00;
		end else begin
			if (wr_low) begin
				int_enable   <= pwdata[7:2];                         // [R24]
				role_request <= pwdata[`LOW_ROLE_BIT];               // [R16]
			end
			if (wr_up) begin
				retry_enable       <= pwdata[`UP_RETRY_BIT];
				cancel_enable      <= pwdata[`UP_CANCEL_BIT];
				every_frame_select <= pwdata[`UP_EVERY_FRAME_BIT];
				upper_reserved     <= pwdata[7:3];
			end
			if (wr_side) begin
				soft_reset          <= pwdata[`SIDE_SOFT_RESET_BIT];
				frame_compare_value <= pwdata[15:8];
			end
			if (soft_reset) begin
				bus_reset_command <= 1'b0;                           // [R4] [R13]
				reset_count       <= 32'h0;
			end else if (bus_reset_command) begin
				if (reset_done) begin
					bus_reset_command <= 1'b0;                       // [R11]
					reset_count       <= 32'h0;
				end else begin
					reset_count <= reset_count + 32'h1;
				end
			end else if (wr_low && pwdata[`LOW_BUS_RESET_BIT]) begin
				bus_reset_command <= 1'b1;                           // [R11] [R12]
			end
		end
	end

	// -------------------------------------------------------------------------
	// Role switch: lags the request, readback shows the actual role
	// -------------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_role  <= 1'b0;
			role_count <= 3'h0;
		end else if (role_request == host_role) begin
			role_count <= 3'h0;
		end else if (role_count == `ROLE_SETTLE_CYCLES - 1) begin
			host_role  <= role_request;                              // [R18]
			role_count <= 3'h0;
		end else begin
			role_count <= role_count + 3'h1;
		end
	end

	// -------------------------------------------------------------------------
	// Token launch, cancel and retry window
	// -------------------------------------------------------------------------
	wire retry_cause = token_nak | token_error;
	wire retry_open  = retry_count < retry_period;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			token_launch <= 1'b0;
			token_retry  <= 1'b0;
			token_active <= 1'b0;
			retry_count  <= {RETRY_WIDTH{1'b0}};
		end else begin
			token_launch <= token_write & ~cancel_hit;               // [R5] [R6]
			token_retry  <= token_active & retry_enable & retry_cause & retry_open; // [R8] [R9]
			if (soft_reset || token_done || (retry_cause && !(retry_enable && retry_open))) begin
				token_active <= 1'b0;
				retry_count  <= {RETRY_WIDTH{1'b0}};
			end else if (token_write && !cancel_hit) begin
				token_active <= 1'b1;
				retry_count  <= {RETRY_WIDTH{1'b0}};
			end else if (token_active && retry_open) begin
				retry_count <= retry_count + {{(RETRY_WIDTH-1){1'b0}}, 1'b1}; // [R9]
			end
		end
	end

	// -------------------------------------------------------------------------
	// Interrupt and bus reset outputs
	// -------------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_irq        <= 1'b0;
			bus_reset_drive <= 1'b0;
		end else begin
			host_irq        <= |(host_event_flags[5:0] & int_enable); // [R10]
			bus_reset_drive <= bus_reset_command & ~reset_done & ~soft_reset;
		end
	end

	// -------------------------------------------------------------------------
	// APB read path: zero wait states, error on unmapped address
	// -------------------------------------------------------------------------
	always @* begin
		next_prdata = 32'h0;
		case (paddr)
			`ADDR_HOST_CONTROL_LOWER: next_prdata[7:0] =
				{int_enable, bus_reset_command, host_role};
			`ADDR_HOST_CONTROL_UPPER: next_prdata[7:0] =
				{upper_reserved, every_frame_select, cancel_enable, retry_enable};
			`ADDR_HOST_EVENT_FLAGS:   next_prdata[7:0] = host_event_flags;
			`ADDR_SIDE_CONTROL:       next_prdata[15:0] = {frame_compare_value, 7'h00, soft_reset};
			default:                  next_prdata = 32'h0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= (psel && !penable && !pwrite) ? next_prdata : prdata;
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped(paddr);
		end
	end

endmodule

//--- usb_host_ctrl_props.sv
// Assertions on the host control block's ports, bound to it below.
// Assumes one pclk domain and presetn asynchronous, active low.
`timescale 1ns/10ps
module usb_host_ctrl_props #(
	parameter BUS_RESET_CYCLES = 8,
	parameter RETRY_WIDTH      = 24
) (
	input wire                   pclk,
	input wire                   presetn,
	input wire                   psel,
	input wire                   penable,
	input wire                   pwrite,
	input wire [11:0]            paddr,
	input wire [31:0]            pwdata,
	input wire                   token_write,
	input wire                   eof_window,
	input wire                   token_nak,
	input wire                   token_error,
	input wire [RETRY_WIDTH-1:0] retry_period,
	input wire                   token_launch,
	input wire                   token_retry,
	input wire                   bus_reset_drive,
	input wire                   soft_reset
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Length of the current bus reset, in cycles
	int unsigned drv_cnt;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			drv_cnt <= 0;
		else
			drv_cnt <= bus_reset_drive ? drv_cnt + 1 : 0;
	end
	sequence s_low_wr;
		psel && penable && pwrite && paddr == 12'h000 && !bus_reset_drive;
	endsequence
	sequence s_go;
		s_low_wr ##0 (pwdata[1] && !soft_reset);
	endsequence
	sequence s_blk;
		s_low_wr ##0 (pwdata[1] && soft_reset);
	endsequence
	sequence s_nop;
		s_low_wr ##0 !pwdata[1];
	endsequence
	a_reset_starts: assert property (s_go |-> ##[1:3] bus_reset_drive)
		else $error("bus reset did not start");
	a_reset_length: assert property ($fell(bus_reset_drive) |->
		drv_cnt >= BUS_RESET_CYCLES - 1 && drv_cnt <= BUS_RESET_CYCLES + 2)
		else $error("bus reset length wrong");
	a_zero_write: assert property (s_nop |=> !bus_reset_drive [*3])
		else $error("zero write started a bus reset");
	a_soft_blocks: assert property (s_blk |=> !bus_reset_drive [*4])
		else $error("bus reset started under soft reset");
	a_launch_open: assert property (token_write && !eof_window |=> token_launch)
		else $error("token outside window not sent");
	a_launch_cause: assert property (token_launch |-> $past(token_write))
		else $error("token sent without a request");
	a_retry_cause: assert property (token_retry |-> $past(token_nak || token_error))
		else $error("retry without nak or error");
	a_retry_window: assert property (token_retry |-> retry_period != 0)
		else $error("retry with empty retry period");
endmodule

bind usb_host_control_regs usb_host_ctrl_props #(
	.BUS_RESET_CYCLES(BUS_RESET_CYCLES),
	.RETRY_WIDTH(RETRY_WIDTH)
) u_props (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .token_write,
	.eof_window, .token_nak, .token_error, .retry_period, .token_launch,
	.token_retry, .bus_reset_drive, .soft_reset
);

//--- usb_far_side.sv
// Far-side model: protocol engine pulses and USB line events.
// Assumes the bench calls its task right after a rising pclk edge.
`timescale 1ns/10ps
module usb_far_side (
	input  wire       pclk,
	output reg  [7:0] ev,
	output reg  [7:0] frame
);
	initial ev = 8'h00;
	initial frame = 8'h00;
	// Pulses last one cycle; line levels (bits 7:5) stay up for the synchroniser
	task pulse(input [7:0] m, input [7:0] f);
		ev <= m;
		frame <= f;
		@(posedge pclk);
		ev <= m & 8'he0;
		// Frame number is only valid with its strobe, so scramble it after
		frame <= ~f;
		repeat (4) @(posedge pclk);
		ev <= 8'h00;
		@(posedge pclk);
	endtask
endmodule

//--- tb_top.sv
// Bench for the host control block: APB master, register model, checks.
// Assumes the far-side model and the bound checker are compiled with it.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_top;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic        pready, pslverr, token_write = 0, eof_window = 0, token_launch;
	logic        token_retry, bus_reset_drive, host_role, soft_reset, host_irq;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [23:0] retry_period = 24'h64;
	logic [7:0]  ev, frame;
	int          n_mismatch = 0, checked = 0, n_retry = 0, k, i, x;
	int          lo = 0, up = 1, fl = 0, sd = 0, bsy = 0;
	bit   [31:0] seed = 32'h00011f55;
	bit   [7:0]  msk [6] = '{8'h01, 8'h80, 8'h40, 8'h04, 8'h00, 8'h20};
	usb_host_control_regs #(.BUS_RESET_CYCLES(8)) dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .sof_sent(ev[0]), .sof_by_token(ev[1]), .frame_number_low(frame),
		.token_write, .eof_window, .token_done(ev[2]), .token_nak(ev[3]),
		.token_error(ev[4]), .retry_period, .resume_event(ev[5]), .attach_event(ev[6]),
		.detach_event(ev[7]), .token_launch, .token_retry, .bus_reset_drive, .host_role,
		.soft_reset, .host_irq);
	usb_far_side far (.pclk, .ev, .frame);
	always #5 pclk = ~pclk;
	always @(posedge pclk) if (token_retry === 1'b1) n_retry++;
	function automatic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// One idle cycle after each transfer keeps every signal to one update per step
	task apb(input w, input [11:0] a, input [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(input [11:0] a);
		apb(1'b0, a, 32'h0);
		case (a)
			12'h000: x = lo | bsy << 1;
			12'h004: x = up;
			12'h008: x = fl;
			12'h00c: x = sd;
			default: x = 0;
		endcase
		`CHK(r, 32'(x))
		`CHK(e, a > 12'h00c)
	endtask
	task wr(input [11:0] a, input [31:0] d);
		apb(1'b1, a, d);
		case (a)
			12'h000: begin
				lo = d & 32'hfd;
				bsy = d[1] & ~sd[0];
			end
			12'h004: up = d & 32'hff;
			12'h008: fl = fl & d;
			12'h00c: begin
				sd = d & 32'hff01;
				if (d[0]) fl = fl & 32'h06;
			end
		endcase
	endtask
	task irq(input v);
		repeat (2) @(negedge pclk);
		`CHK(host_irq, v)
		@(posedge pclk);
	endtask
	task tok(input v);
		token_write <= 1'b1;
		@(posedge pclk);
		token_write <= 1'b0;
		@(negedge pclk);
		`CHK(token_launch, v)
		@(posedge pclk);
	endtask
	task print_verdict;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		print_verdict;
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 20; i += 4) rd(12'(i));
		repeat (3) begin
			wr(12'h004, rnd() & 32'h7);
			rd(12'h004);
			wr(12'h000, rnd() & 32'hfc);
			rd(12'h000);
		end
		wr(12'h004, 32'h5);
		wr(12'h000, 32'h0);
		far.pulse(8'h01, 8'h33);
		fl = fl | 1;
		rd(12'h008);
		wr(12'h008, 32'hfe);
		rd(12'h008);
		far.pulse(8'h03, 8'h33);
		rd(12'h008);
		wr(12'h004, 32'h1);
		wr(12'h00c, 32'h5a00);
		far.pulse(8'h01, 8'h11);
		rd(12'h008);
		far.pulse(8'h01, 8'h5a);
		fl = fl | 1;
		rd(12'h008);
		wr(12'h008, 32'h0);
		wr(12'h004, 32'h5);
		for (i = 0; i < 6; i++) begin
			if (msk[i] != 8'h00) begin
				wr(12'h000, 32'h0);
				far.pulse(msk[i], 8'h00);
				fl = fl | 1 << i;
				irq(1'b0);
				wr(12'h000, 32'h4 << i);
				irq(1'b1);
				rd(12'h008);
				wr(12'h008, ~(32'h1 << i));
				irq(1'b0);
			end
		end
		wr(12'h004, 32'h3);
		eof_window <= 1'b1;
		tok(1'b0);
		fl = fl | 32'h80;
		rd(12'h008);
		wr(12'h004, 32'h1);
		tok(1'b1);
		eof_window <= 1'b0;
		wr(12'h008, 32'h7f);
		tok(1'b1);
		far.pulse(8'h08, 8'h00);
		far.pulse(8'h10, 8'h00);
		`CHK(n_retry, 2)
		repeat (120) @(posedge pclk);
		far.pulse(8'h08, 8'h00);
		`CHK(n_retry, 2)
		wr(12'h004, 32'h0);
		tok(1'b1);
		far.pulse(8'h08, 8'h00);
		`CHK(n_retry, 2)
		retry_period <= 24'h0;
		wr(12'h004, 32'h1);
		tok(1'b1);
		far.pulse(8'h10, 8'h00);
		`CHK(n_retry, 2)
		// Not suspended and no token in flight when the bus reset starts
		wr(12'h000, 32'h42);
		rd(12'h000);
		// No control write until the command bit reads back 0
		for (k = 0; k < 40 && r[1] !== 1'b0; k++) apb(1'b0, 12'h000, 32'h0);
		bsy = 0;
		fl = fl | 32'h10;
		rd(12'h000);
		rd(12'h008);
		irq(1'b1);
		wr(12'h008, 32'hef);
		wr(12'h000, 32'h40);
		`CHK(bus_reset_drive, 1'b0)
		far.pulse(8'h40, 8'h00);
		fl = fl | 32'h04;
		wr(12'h00c, 32'h1);
		wr(12'h000, 32'h42);
		rd(12'h000);
		rd(12'h004);
		rd(12'h008);
		// Host-connect and upstream disconnect live outside this block
		wr(12'h000, 32'h41);
		@(negedge pclk);
		`CHK(host_role, 1'b0)
		repeat (8) @(negedge pclk);
		`CHK(host_role, 1'b1)
		@(posedge pclk);
		rd(12'h000);
		print_verdict;
	end
endmodule
